// File: core/mcac_pkg.sv
// Constants and types for the measurement cycle converter control block
package mcac_pkg;
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_COEF = 8'h08;
  localparam logic [7:0] A_SIG = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_PRES = 8'h14;
  localparam logic [7:0] A_TMP1 = 8'h18;
  localparam logic [7:0] A_TMP2 = 8'h1c;
  // Control field positions
  localparam int C_RUN = 0;
  localparam int C_EXT = 1;
  localparam int C_INJ = 2;
  // Configuration field positions
  localparam int F_NP = 0;
  localparam int F_TEMP2_EN = 3;
  localparam int F_ORD = 4;
  localparam int F_RES = 5;
  localparam int F_ZERO_SHIFT = 9;
  localparam int F_XZS = 11;
  localparam int F_TZS = 17;
  localparam int F_GAIN = 23;
  localparam int F_TSRC = 27;
  // Reset values and diagnostic output value
  localparam logic [31:0] CFG_RST = 32'h0000_0180;
  localparam logic [31:0] COEF_RST = 32'h0000_1000;
  localparam logic [15:0] SIG_RST = 16'h1180;
  localparam logic [15:0] DIAG_VAL = 16'hffff;
  // Resolution limits
  localparam logic [3:0] RES1_MIN = 4'h9;
  localparam logic [3:0] RES2_MIN = 4'ha;
  localparam logic [3:0] RES_MAX = 4'hf;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int PROC_NS = 2000;
  localparam int PROC_CYC = PROC_NS / CLK_PERIOD_NS;
  localparam int GAIN_SHIFT = 12;
  // Input sources and cycle steps
  typedef enum logic [2:0] {SRC_DIODE, SRC_PN, SRC_BRIDGE_R, SRC_THERM, SRC_SHORT, SRC_AMP}
    mcac_src_e;
  typedef enum logic [2:0] {K_P, K_AZP, K_AZT1, K_T1, K_AZT2, K_T2} mcac_kind_e;
endpackage

// File: core/mcac_top.sv
// Measurement cycle sequencer, converter control, correction and safety checks
// Operation
// - start routine precedes regular cycle
// - pressure repeat count 1 to 128
// - fixed regular cycle step order
// - second temperature enable gates its steps
// - input source chosen per step
// - first order takes 2^R microseconds
// - first order resolution 9 to 15
// - first order count out of 2^R
// - zero shift from stored setting
// - second order two stacked conversions
// - second order resolution 10 to 15
// - combined count from two stages
// - sample rate follows order; outputs capped
// - sample includes processing after conversion
// - 16-bit correction with stored coefficients
// - start on control run bit, internal or external clock
// - signature check at initialization
// - parity check of registers in every state but idle
// - error sets flag, forces diagnostic outputs
// - offset shift step depends on gain
// - two 6-bit offset shift fields
//
// Design decisions made here: the register offsets and the APB slave port.
module mcac_top
  import mcac_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Front end
  input wire logic mod_bit_i,
  input wire logic ext_clk_i,
  output logic [2:0] mux_sel_o,
  output logic conv_busy_o,
  output logic [1:0] zero_point_shift_o,
  output logic [5:0] extended_offset_shift_o,
  output logic [5:0] temp_zero_shift_o,
  output logic [3:0] gain_sel_o,
  output logic [3:0] offset_step_pct_o,
  // Results
  output logic [15:0] pres_o,
  output logic [15:0] temp1_o,
  output logic [15:0] temp2_o,
  output logic [10:0] analog_code_o,
  output logic [11:0] pwm_code_o,
  output logic sample_o,
  output logic err_flag_o
);
  typedef enum logic [2:0] {S_IDLE, S_SIG, S_CONV, S_PROC, S_ERR} mcac_state_e;
  mcac_state_e st_r;
  logic [1:0] ctrl_r;
  logic [31:0] cfg_r, coef_r;
  logic [15:0] sig_r;
  logic [2:0] par_r;
  logic sig_err_r, par_err_r;
  logic [15:0] pres_r, tmp1_r, tmp2_r, azp_r, azt1_r, azt2_r, cnt_r, first_stage_count_r;
  logic [15:0] tk_r, ones_r;
  logic act_ord_r, stg_r, start_r, sample_r;
  logic [3:0] act_res_r, idx_r;
  logic [7:0] rep_r, div_r, pc_r;
  logic m_s1, m_s2, e_s1, e_s2, e_s3;
  // APB decode
  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i;
  wire h_ctrl = paddr_i == A_CTRL;
  wire h_cfg = paddr_i == A_CFG;
  wire h_coef = paddr_i == A_COEF;
  wire h_sig = paddr_i == A_SIG;
  wire h_ro = (paddr_i == A_STAT) | (paddr_i == A_PRES) | (paddr_i == A_TMP1) |
              (paddr_i == A_TMP2);
  wire mapped = h_ctrl | h_cfg | h_coef | h_sig | h_ro;
  wire [3:0] w_res = pwdata_i[F_RES +: 4];
  wire w_ord = pwdata_i[F_ORD];
  wire res_ok = (w_res <= RES_MAX) & (w_res >= (w_ord ? RES2_MIN : RES1_MIN));
  wire bad_wr = pwrite_i & ((h_cfg & !res_ok) | h_ro);
  wire cfg_we = wr & h_cfg & res_ok;
  assign pready_o = 1'b1;
  assign pslverr_o = acc & (!mapped | bad_wr);

  // Stored settings with parity bits
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_r <= 2'h0;
      cfg_r <= CFG_RST;
      coef_r <= COEF_RST;
      sig_r <= SIG_RST;
      par_r <= {^SIG_RST, ^COEF_RST, ^CFG_RST};
    end else if (wr) begin
      if (h_ctrl) begin
        ctrl_r <= pwdata_i[1:0];
        par_r[0] <= par_r[0] ^ pwdata_i[C_INJ]; // Fault injection hook
      end
      if (cfg_we) begin
        cfg_r <= pwdata_i;
        par_r[0] <= ^pwdata_i;
      end
      if (h_coef) begin
        coef_r <= pwdata_i;
        par_r[1] <= ^pwdata_i;
      end
      if (h_sig) begin
        sig_r <= pwdata_i[15:0];
        par_r[2] <= ^pwdata_i[15:0];
      end
    end
  end
  // Setting fields to the front end
  wire second_temp_enable = cfg_r[F_TEMP2_EN];
  wire [7:0] n_rep = 8'h1 << cfg_r[F_NP +: 3];
  assign zero_point_shift_o = cfg_r[F_ZERO_SHIFT +: 2];
  assign extended_offset_shift_o = cfg_r[F_XZS +: 6];
  assign temp_zero_shift_o = cfg_r[F_TZS +: 6];
  assign gain_sel_o = cfg_r[F_GAIN +: 4];
  // Offset shift step in percent of span per gain setting
  function automatic logic [3:0] step_pct(input logic [3:0] g);
    case (g)
      4'h0, 4'h2, 4'h9: step_pct = 4'hf;
      4'h1, 4'h3, 4'h5, 4'h7, 4'ha: step_pct = 4'h9;
      4'h4, 4'h6, 4'h8, 4'hb: step_pct = 4'h6;
      4'hc: step_pct = 4'h1;
      default: step_pct = 4'h0;
    endcase
  endfunction
  assign offset_step_pct_o = step_pct(gain_sel_o);
  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    m_s1 <= mod_bit_i;
    m_s2 <= m_s1;
    e_s1 <= ext_clk_i;
    e_s2 <= e_s1;
    e_s3 <= e_s2;
  end
  // Microsecond tick from internal divider or external clock edge
  wire tick_int = div_r == 8'(TICK_CYC - 1);
  wire tick = ctrl_r[C_EXT] ? (e_s2 & !e_s3) : tick_int;
  always_ff @(posedge clk_i) begin
    if (!rstn_i || tick_int) div_r <= 8'h0;
    else div_r <= div_r + 8'h1;
  end

  // Step tables
  function automatic mcac_kind_e kind_of(input logic st, input logic [3:0] i);
    if (st) begin
      case (i)
        4'h0: kind_of = K_P;
        4'h1: kind_of = K_AZP;
        4'h2: kind_of = K_AZT1;
        4'h3: kind_of = K_T1;
        4'h4: kind_of = K_AZT2;
        default: kind_of = K_T2;
      endcase
    end else begin
      case (i)
        4'h1: kind_of = K_AZT1;
        4'h3: kind_of = K_T1;
        4'h5: kind_of = K_AZP;
        4'h7: kind_of = K_AZT2;
        4'h9: kind_of = K_T2;
        default: kind_of = K_P;
      endcase
    end
  endfunction
  wire mcac_kind_e kind = kind_of(start_r, idx_r);
  wire [2:0] mux_kind = kind;
  wire [3:0] last_idx = start_r ? (second_temp_enable ? 4'h5 : 4'h3) :
                        (second_temp_enable ? 4'h9 : 4'h5);
  wire more_rep = !start_r & (kind == K_P) & (rep_r + 8'h1 < n_rep);

  // Input selection per step
  wire [2:0] tsrc = {1'b0, cfg_r[F_TSRC +: 2]};
  assign mux_sel_o = (kind == K_P) ? SRC_AMP :
                     (kind == K_T1) ? tsrc :
                     (kind == K_T2) ? SRC_THERM : SRC_SHORT;
  assign conv_busy_o = st_r == S_CONV;

  // Read data mux
  wire [31:0] stat_w = {25'h0, mux_kind, st_r == S_CONV, par_err_r, sig_err_r, err_flag_o};
  assign prdata_o = !(acc & !pwrite_i) ? 32'h0 :
                    h_ctrl ? {30'h0, ctrl_r} :
                    h_cfg ? cfg_r :
                    h_coef ? coef_r :
                    h_sig ? {16'h0, sig_r} :
                    (paddr_i == A_STAT) ? stat_w :
                    (paddr_i == A_PRES) ? {16'h0, pres_r} :
                    (paddr_i == A_TMP1) ? {16'h0, tmp1_r} :
                    (paddr_i == A_TMP2) ? {16'h0, tmp2_r} : 32'h0;

  // Conversion arithmetic
  wire [3:0] half = 4'(({1'b0, act_res_r} + 5'h1) >> 1); // Five bits so 15 does not wrap
  wire [15:0] total = act_ord_r ? (16'h1 << half) : (16'h1 << act_res_r);
  wire [15:0] ones_nx = ones_r + {15'h0, m_s2};
  wire conv_end = (st_r == S_CONV) & tick & (tk_r + 16'h1 == total);
  wire [15:0] comb2 = 16'(first_stage_count_r << (half - 4'h1)) + ones_nx;
  wire proc_end = (st_r == S_PROC) & (pc_r == 8'(PROC_CYC - 1));

  // Correction with offset and gain coefficients
  wire [15:0] az_sel = (kind == K_T1) ? azt1_r : (kind == K_T2) ? azt2_r : azp_r;
  wire signed [16:0] diff = $signed({1'b0, cnt_r}) - $signed({1'b0, az_sel});
  wire signed [32:0] prod = diff * $signed(coef_r[15:0]);
  wire signed [32:0] corr = (prod >>> GAIN_SHIFT) + 33'($signed(coef_r[31:16]));
  wire [15:0] corr16 = corr[32] ? 16'h0 : (|corr[31:16]) ? 16'hffff : corr[15:0];

  // Safety checks
  wire [15:0] sig_sum = cfg_r[15:0] + cfg_r[31:16] + coef_r[15:0] + coef_r[31:16];
  wire sig_bad = sig_sum != sig_r;
  wire par_bad = (^{cfg_r, par_r[0]}) | (^{coef_r, par_r[1]}) | (^{sig_r, par_r[2]});
  wire sig_set = (st_r == S_SIG) & sig_bad;
  wire par_set = (st_r != S_IDLE) & par_bad;
  wire err_set = sig_set | par_set;
  assign err_flag_o = sig_err_r | par_err_r;

  // Sequencer state machine
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_r <= S_IDLE;
    end else if (err_set) begin
      st_r <= S_ERR;
    end else begin
      case (st_r)
        S_IDLE: if (ctrl_r[C_RUN]) st_r <= S_SIG;
        S_SIG: st_r <= S_CONV;
        S_CONV: if (conv_end && (!act_ord_r || stg_r)) st_r <= S_PROC;
        S_PROC: if (proc_end) st_r <= S_CONV;
        S_ERR: st_r <= S_ERR;
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Conversion counters; settings latched only as a conversion begins
  wire conv_start = ((st_r == S_SIG) & !sig_bad) | proc_end;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      act_ord_r <= 1'b0;
      act_res_r <= RES1_MIN;
      stg_r <= 1'b0;
      tk_r <= 16'h0;
      ones_r <= 16'h0;
      first_stage_count_r <= 16'h0;
      cnt_r <= 16'h0;
      pc_r <= 8'h0;
    end else if (conv_start) begin
      act_ord_r <= cfg_r[F_ORD];
      act_res_r <= cfg_r[F_RES +: 4];
      stg_r <= 1'b0;
      tk_r <= 16'h0;
      ones_r <= 16'h0;
    end else if (st_r == S_CONV && tick) begin
      if (conv_end) begin
        tk_r <= 16'h0;
        ones_r <= 16'h0;
        pc_r <= 8'h0;
        if (act_ord_r && !stg_r) begin
          first_stage_count_r <= ones_nx;
          stg_r <= 1'b1;
        end else begin
          cnt_r <= act_ord_r ? comb2 : ones_nx;
        end
      end else begin
        tk_r <= tk_r + 16'h1;
        ones_r <= ones_nx;
      end
    end else if (st_r == S_PROC) begin
      pc_r <= pc_r + 8'h1;
    end
  end

  // Step pointer: start routine, then endless regular cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      start_r <= 1'b1;
      idx_r <= 4'h0;
      rep_r <= 8'h0;
    end else if (proc_end) begin
      if (more_rep) begin
        rep_r <= rep_r + 8'h1;
      end else begin
        rep_r <= 8'h0;
        if (idx_r >= last_idx) begin
          idx_r <= 4'h0;
          start_r <= 1'b0;
        end else begin
          idx_r <= idx_r + 4'h1;
        end
      end
    end
  end

  // Results, auto zeros and error flags
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pres_r <= 16'h0;
      tmp1_r <= 16'h0;
      tmp2_r <= 16'h0;
      azp_r <= 16'h0;
      azt1_r <= 16'h0;
      azt2_r <= 16'h0;
      sig_err_r <= 1'b0;
      par_err_r <= 1'b0;
      sample_r <= 1'b0;
    end else begin
      sample_r <= proc_end & !err_set;
      if (sig_set) sig_err_r <= 1'b1;
      if (par_set) par_err_r <= 1'b1;
      if (err_set || err_flag_o) begin
        pres_r <= DIAG_VAL;
        tmp1_r <= DIAG_VAL;
        tmp2_r <= DIAG_VAL;
      end else if (proc_end) begin
        case (kind)
          K_AZP: azp_r <= cnt_r;
          K_AZT1: azt1_r <= cnt_r;
          K_AZT2: azt2_r <= cnt_r;
          K_T1: tmp1_r <= corr16;
          K_T2: tmp2_r <= corr16;
          default: pres_r <= corr16;
        endcase
      end
    end
  end

  // Output drive; analog and PWM codes are capped in width
  assign pres_o = pres_r;
  assign temp1_o = tmp1_r;
  assign temp2_o = tmp2_r;
  assign analog_code_o = pres_r[15:5];
  assign pwm_code_o = pres_r[15:4];
  assign sample_o = sample_r;

  // Checks
  property p_res1;
    @(posedge clk_i) disable iff (!rstn_i)
      !cfg_r[F_ORD] |-> cfg_r[F_RES +: 4] >= RES1_MIN && cfg_r[F_RES +: 4] <= RES_MAX;
  endproperty
  a_res1: assert property (p_res1) else $error("first order resolution out of range");
  property p_res2;
    @(posedge clk_i) disable iff (!rstn_i)
      cfg_r[F_ORD] |-> cfg_r[F_RES +: 4] >= RES2_MIN && cfg_r[F_RES +: 4] <= RES_MAX;
  endproperty
  a_res2: assert property (p_res2) else $error("second order resolution out of range");
  property p_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      st_r == S_CONV && $past(st_r) == S_CONV |-> $stable(act_res_r) && $stable(act_ord_r);
  endproperty
  a_hold: assert property (p_hold) else $error("settings changed mid conversion");
  property p_t2_gate;
    @(posedge clk_i) disable iff (!rstn_i)
      $past(proc_end) && !$past(second_temp_enable) |-> kind != K_AZT2 && kind != K_T2;
  endproperty
  a_t2_gate: assert property (p_t2_gate) else $error("temp2 step while disabled");
  property p_sig;
    @(posedge clk_i) disable iff (!rstn_i)
      st_r == S_SIG && sig_bad |=> st_r == S_ERR && err_flag_o;
  endproperty
  a_sig: assert property (p_sig) else $error("signature error not flagged");
  property p_par;
    @(posedge clk_i) disable iff (!rstn_i)
      st_r != S_IDLE && par_bad |=> err_flag_o ##1 st_r == S_ERR;
  endproperty
  a_par: assert property (p_par) else $error("parity error not flagged");
  property p_diag;
    @(posedge clk_i) disable iff (!rstn_i)
      err_flag_o |-> pres_o == DIAG_VAL && temp1_o == DIAG_VAL && temp2_o == DIAG_VAL;
  endproperty
  a_diag: assert property (p_diag) else $error("outputs not diagnostic in error");
  property p_proc;
    @(posedge clk_i) disable iff (!rstn_i)
      conv_end && (!act_ord_r || stg_r) && !err_set |=> (st_r == S_PROC)[*8];
  endproperty
  a_proc: assert property (p_proc) else $error("processing phase missing");
  property p_comb;
    @(posedge clk_i) disable iff (!rstn_i)
      conv_end && act_ord_r && stg_r |=>
        cnt_r == 16'($past(first_stage_count_r) * ($past(total) >> 1)) + $past(ones_nx);
  endproperty
  a_comb: assert property (p_comb) else $error("second order count wrong");
  property p_loop;
    @(posedge clk_i) disable iff (!rstn_i)
      proc_end && !more_rep && idx_r >= last_idx && !err_set |=> idx_r == 4'h0 && !start_r
        && st_r == S_CONV;
  endproperty
  a_loop: assert property (p_loop) else $error("cycle did not restart");
  c_ord2: cover property (@(posedge clk_i) disable iff (!rstn_i) conv_end && act_ord_r && stg_r);
  c_t2: cover property (@(posedge clk_i) disable iff (!rstn_i) proc_end && kind == K_T2);
  c_err: cover property (@(posedge clk_i) disable iff (!rstn_i) par_set);
  c_reg: cover property (@(posedge clk_i) disable iff (!rstn_i) proc_end && !start_r);
endmodule

// File: dv/mcac_front_model.sv
// Front end model: converter bit stream and external tick clock
module mcac_front_model
  import mcac_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Controls from the block
  input wire logic [2:0] mux_sel_i,
  input wire logic conv_busy_i,
  // Converter side
  output logic mod_bit_o,
  output logic ext_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r = 2'h0;
  // Shorted input balances to no ones, every other source to full scale
  assign mod_bit_o = (mux_sel_i != SRC_SHORT);
  // Tick clock runs only while converting, four clocks a period
  always @(posedge clk_i) begin
    ph_r <= conv_busy_i ? ph_r + 2'h1 : 2'h0;
  end
  assign ext_clk_o = ph_r[1];
endmodule

// File: dv/mcac_top_tb.sv
// Self-checking bench for the measurement cycle converter control
module mcac_top_tb
  import mcac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bprev = 1'b0, act = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, cfg, coef;
  logic pready, pslverr, mod_bit, ext_clk, busy, sample, err;
  logic [2:0] mux_sel;
  logic [1:0] zshift;
  logic [5:0] xzs, tzs;
  logic [3:0] gain, pct;
  logic [15:0] pres, t1, t2, off;
  logic [10:0] acode;
  logic [11:0] pcode;
  logic [2:0] q_mux[$];
  logic [2:0] grp[5] = '{3'h4, 3'h1, 3'h4, 3'h4, 3'h3};
  logic [3:0] pct_tab[16] = '{4'hf, 4'h9, 4'hf, 4'h9, 4'h6, 4'h9, 4'h6, 4'h9, 4'h6, 4'hf,
    4'h9, 4'h6, 4'h1, 4'h0, 4'h0, 4'h0};
  int failures = 0, tests_run = 0, cyc = 0, cur_ticks = 0, lat = 0, blen = 0, gap = 0;

  // Design and front end
  mcac_top dut (.clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .mod_bit_i(mod_bit), .ext_clk_i(ext_clk),
    .mux_sel_o(mux_sel), .conv_busy_o(busy), .zero_point_shift_o(zshift),
    .extended_offset_shift_o(xzs), .temp_zero_shift_o(tzs), .gain_sel_o(gain),
    .offset_step_pct_o(pct), .pres_o(pres), .temp1_o(t1), .temp2_o(t2),
    .analog_code_o(acode), .pwm_code_o(pcode), .sample_o(sample), .err_flag_o(err));
  mcac_front_model fe (.clk_i(clk), .mux_sel_i(mux_sel), .conv_busy_i(busy),
    .mod_bit_o(mod_bit), .ext_clk_o(ext_clk));

  // Clock and hang guard
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      results();
    end
  end

  task automatic results();
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask

  // One APB transfer; waits for pready, checks the error response
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    chk("pslverr", 32'(e), 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(nm, exp, rd);
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    act = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask

  task automatic waitq(input int k);
    while (q_mux.size() > k) @(posedge clk);
  endtask

  function automatic logic [15:0] sgn(input logic [31:0] c, input logic [31:0] k);
    return c[15:0] + c[31:16] + k[15:0] + k[31:16];
  endfunction

  // Watcher: takes the oldest expected source at each conversion start, times each step
  always @(posedge clk) begin
    if (act && busy === 1'b1 && bprev !== 1'b1) begin
      lat = cur_ticks;
      blen = 0;
      if (q_mux.size() > 0) chk("mux_sel", 32'(q_mux.pop_front()), 32'(mux_sel));
    end
    if (busy === 1'b1) blen++;
    if (act && busy !== 1'b1 && bprev === 1'b1) begin
      chk("conv_len", lat * 4, (blen >= lat * 4 - 4 && blen <= lat * 4 + 8) ? lat * 4 : blen);
      gap = 0;
    end else begin
      gap++;
    end
    if (act && sample === 1'b1 && lat > 0) begin
      chk("sample_gap", 1, 32'(gap >= PROC_CYC - 2 && gap <= PROC_CYC + 3));
    end
    bprev = busy;
  end

  // Main sequence
  initial begin
    void'($urandom(32'h15ec7efb));
    do_reset();
    chk("err", 32'h0, 32'(err));
    rdc("cfg", A_CFG, CFG_RST);
    rdc("coef", A_COEF, COEF_RST);
    rdc("sig", A_SIG, 32'(SIG_RST));
    rdc("stat", A_STAT, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 1'b1);
    apb(1'b1, A_STAT, 32'h0, 1'b1);
    apb(1'b1, A_CFG, 32'h0000_0100, 1'b1);
    apb(1'b1, A_CFG, 32'h0000_0130, 1'b1);
    rdc("cfg", A_CFG, CFG_RST);
    apb(1'b1, A_CFG, 32'h0000_0120, 1'b0);
    apb(1'b1, A_CFG, 32'h0000_01f0, 1'b0);
    // Gain index sweep with random shift fields
    for (int g = 0; g < 16; g++) begin
      cfg = CFG_RST | (32'(g) << F_GAIN) | ($urandom & 32'h007f_fe00);
      apb(1'b1, A_CFG, cfg, 1'b0);
      chk("step_pct", 32'(pct_tab[g]), 32'(pct));
      chk("zero_shift", 32'(cfg[10:9]), 32'(zshift));
      chk("ext_offset", 32'(cfg[16:11]), 32'(xzs));
      chk("temp_zero", 32'(cfg[22:17]), 32'(tzs));
      chk("gain_sel", 32'(cfg[26:23]), 32'(gain));
    end
    // Second order 10 bit, n of 2, second temperature on, converter resolution above output use
    cfg = 32'h0800_0159;
    off = 16'($urandom & 32'hff);
    coef = {off, 16'h1000};
    apb(1'b1, A_CFG, cfg, 1'b0);
    apb(1'b1, A_COEF, coef, 1'b0);
    rdc("coef", A_COEF, coef);
    apb(1'b1, A_SIG, 32'(sgn(cfg, coef)), 1'b0);
    q_mux = '{3'h5, 3'h4, 3'h4, 3'h1, 3'h4, 3'h3};
    repeat (2) foreach (grp[i]) begin
      repeat (2) q_mux.push_back(3'h5);
      q_mux.push_back(grp[i]);
    end
    cur_ticks = 64;
    act = 1'b1;
    apb(1'b1, A_CTRL, 32'h3, 1'b0);
    waitq(2);
    apb(1'b1, A_CFG, (cfg & ~32'h0000_01f0) | 32'h0000_0120, 1'b0);
    cur_ticks = 512;
    waitq(0);
    while (busy === 1'b1) @(posedge clk);
    while (sample !== 1'b1) @(posedge clk);
    @(posedge clk);
    rdc("pres", A_PRES, 32'(512 + off));
    rdc("temp1", A_TMP1, 32'(544 + off));
    rdc("temp2", A_TMP2, 32'(512 + off));
    chk("analog", 32'((512 + off) >> 5), 32'(acode));
    chk("pwm", 32'((512 + off) >> 4), 32'(pcode));
    chk("pres_o", 32'(512 + off), 32'(pres));
    chk("temp1_o", 32'(544 + off), 32'(t1));
    chk("temp2_o", 32'(512 + off), 32'(t2));
    // Parity fault injected while running; the cut conversion has no length to check
    act = 1'b0;
    apb(1'b1, A_CTRL, 32'h7, 1'b0);
    repeat (3) @(posedge clk);
    chk("err", 32'h1, 32'(err));
    chk("pres_diag", 32'(DIAG_VAL), 32'(pres));
    chk("t2_diag", 32'(DIAG_VAL), 32'(t2));
    chk("busy", 32'h0, 32'(busy));
    apb(1'b0, A_STAT, 32'h0, 1'b0);
    chk("stat", 32'h5, rd & 32'h5);
    // Signature mismatch at start
    do_reset();
    apb(1'b1, A_CFG, cfg, 1'b0);
    apb(1'b1, A_CTRL, 32'h3, 1'b0);
    repeat (4) @(posedge clk);
    chk("err", 32'h1, 32'(err));
    chk("t1_diag", 32'(DIAG_VAL), 32'(t1));
    apb(1'b0, A_STAT, 32'h0, 1'b0);
    chk("stat", 32'h3, rd & 32'h3);
    results();
  end
endmodule
